// ### rtl/dpmh_host.sv
`timescale 1ns/1ps
// Summary of operation
// - Host clears only its own mailbox flag after power-up by accessing own mailbox.
// - Slave busy inputs held high normally, low to block a port's writes.
// - Stacked devices' busy indications are ANDed into the array busy.
// - Busy indications may be ORed into an illegal-access interrupt.
// - Host holds chip enable high and semaphore select low for semaphores.
module dpmh_host #(
  parameter bit PORT_RIGHT = 1'b0
) (
  input  wire logic                          mclk,
  input  wire logic                          nrst,
  // User command side
  input  wire logic                          cmd_valid,
  output logic                               cmd_ready,
  input  wire logic [1:0]                    cmd_op,
  input  wire logic [dpmh_pkg::ADDR_W-1:0]   cmd_addr,
  input  wire logic [dpmh_pkg::DATA_W-1:0]   cmd_wdata,
  output logic                               rsp_valid,
  output logic [dpmh_pkg::DATA_W-1:0]        rsp_rdata,
  output logic                               rsp_sem_owned,
  output logic                               init_done,
  input  wire logic                          write_lock,
  output logic                               mailbox_irq,
  output logic                               conflict_irq,
  // Device port pins
  output logic [dpmh_pkg::ADDR_W-1:0]        addr,
  output logic [dpmh_pkg::DATA_W-1:0]        data_out,
  output logic                               data_oe,
  input  wire logic [dpmh_pkg::DATA_W-1:0]   data_in,
  output logic                               ce_n,
  output logic                               rw_n,
  output logic                               oe_n,
  output logic                               flag_space_select_n,
  input  wire logic                          own_mailbox_irq_n,
  input  wire logic [dpmh_pkg::DEV_N-1:0]    left_conflict_flag_n,
  input  wire logic [dpmh_pkg::DEV_N-1:0]    right_conflict_flag_n,
  output logic                               slave_busy_hold_n
);
  import dpmh_pkg::*;

  dpmh_state_e         state;
  dpmh_state_e         next_state;
  logic [CNT_W-1:0]    cnt;
  logic                init_pending;
  logic [1:0]          op;
  logic [ADDR_W-1:0]   op_addr;
  logic [DATA_W-1:0]   op_wdata;
  logic [DEV_N-1:0]    lb_s1, lb_s2, rb_s1, rb_s2;
  logic [DATA_W-1:0]   din_s1, din_s2;
  logic                irq_s1, irq_s2;
  logic                busy_l_ok;
  logic                busy_r_ok;
  logic                own_busy_ok;
  logic                is_write;
  logic                is_sem;
  logic [1:0]          cur_op;
  logic [ADDR_W-1:0]   cur_addr;
  logic [DATA_W-1:0]   cur_wdata;
  logic                cur_write;
  logic                cur_sem;

  function automatic logic op_writes(input logic [1:0] o);
    op_writes = (o == OP_RAM_WR) || (o == OP_SEM_WR);
  endfunction

  function automatic logic op_sem(input logic [1:0] o);
    op_sem = (o == OP_SEM_RD) || (o == OP_SEM_WR);
  endfunction

  // Pin inputs pass two flops before use
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lb_s1  <= '1;
      lb_s2  <= '1;
      rb_s1  <= '1;
      rb_s2  <= '1;
      din_s1 <= '0;
      din_s2 <= '0;
      irq_s1 <= 1'b1;
      irq_s2 <= 1'b1;
    end else begin
      lb_s1  <= left_conflict_flag_n;
      lb_s2  <= lb_s1;
      rb_s1  <= right_conflict_flag_n;
      rb_s2  <= rb_s1;
      din_s1 <= data_in;
      din_s2 <= din_s1;
      irq_s1 <= own_mailbox_irq_n;
      irq_s2 <= irq_s1;
    end
  end

  // Any stacked device showing busy makes the array busy
  assign busy_l_ok   = &lb_s2;
  assign busy_r_ok   = &rb_s2;
  assign own_busy_ok = PORT_RIGHT ? busy_r_ok : busy_l_ok;
  assign is_write    = op_writes(op);
  assign is_sem      = op_sem(op);
  assign cmd_ready   = (state == ST_IDLE) && !init_pending;

  // Pins launch on the taking edge, so they must see the command being taken
  always_comb begin
    cur_op    = op;
    cur_addr  = op_addr;
    cur_wdata = op_wdata;
    if (state == ST_IDLE) begin
      if (init_pending) begin
        cur_op   = OP_RAM_RD;
        cur_addr = PORT_RIGHT ? MBOX_RIGHT : MBOX_LEFT;
      end else begin
        cur_op    = cmd_op;
        cur_addr  = cmd_addr;
        cur_wdata = cmd_wdata;
      end
    end
  end

  assign cur_write = op_writes(cur_op);
  assign cur_sem   = op_sem(cur_op);

  // Status flags seen by the user, and the slave busy hold pin
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mailbox_irq       <= 1'b0;
      conflict_irq      <= 1'b0;
      slave_busy_hold_n <= 1'b1;
    end else begin
      mailbox_irq       <= !irq_s2;
      conflict_irq      <= !busy_l_ok || !busy_r_ok;
      slave_busy_hold_n <= !write_lock;
    end
  end

  // Sequencer; writes wait for busy to settle before the strobe
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (init_pending || cmd_valid) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt == '0) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Reads are never inhibited; only a write stalls on busy
        if (!is_write || own_busy_ok) begin
          next_state = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (cnt == '0) begin
          next_state = ST_RECOVER;
        end
      end
      ST_RECOVER: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Phase counter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
    end else if (state == ST_IDLE && next_state == ST_SETUP) begin
      cnt <= CNT_W'(SETUP_CYC - 1);
    end else if (state == ST_WAIT && next_state == ST_STROBE) begin
      cnt <= CNT_W'(STROBE_CYC - 1);
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  // Command capture; the first access clears our own mailbox flag
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      op       <= OP_RAM_RD;
      op_addr  <= '0;
      op_wdata <= '0;
    end else if (state == ST_IDLE && next_state == ST_SETUP) begin
      if (init_pending) begin
        op      <= OP_RAM_RD;
        op_addr <= PORT_RIGHT ? MBOX_RIGHT : MBOX_LEFT;
      end else begin
        op       <= cmd_op;
        op_addr  <= cmd_addr;
        op_wdata <= cmd_wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      init_pending <= RST_INIT_PENDING;
    end else if (state == ST_RECOVER) begin
      init_pending <= 1'b0;
    end
  end

  assign init_done = !init_pending;

  // Pin drive, registered from the next state so pins track the phase
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr                <= '0;
      data_out            <= '0;
      data_oe             <= 1'b0;
      ce_n                <= 1'b1;
      rw_n                <= 1'b1;
      oe_n                <= 1'b1;
      flag_space_select_n <= 1'b1;
    end else begin
      case (next_state)
        ST_SETUP, ST_WAIT, ST_STROBE: begin
          // Semaphore space: chip enable off, select on
          addr                <= cur_sem ? {{(ADDR_W-SEM_IDX_W){1'b0}},
                                            cur_addr[SEM_IDX_W-1:0]} : cur_addr;
          ce_n                <= cur_sem;
          flag_space_select_n <= !cur_sem;
          data_out            <= (cur_op == OP_SEM_WR) ? {{(DATA_W-1){1'b0}}, cur_wdata[0]}
                                                       : cur_wdata;
          data_oe             <= cur_write;
          rw_n                <= !(cur_write && next_state == ST_STROBE);
          oe_n                <= !(!cur_write && next_state == ST_STROBE);
        end
        default: begin
          ce_n                <= 1'b1;
          flag_space_select_n <= 1'b1;
          rw_n                <= 1'b1;
          oe_n                <= 1'b1;
          data_oe             <= 1'b0;
        end
      endcase
    end
  end

  // Answer; a semaphore reading zero means this side holds it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rsp_valid     <= 1'b0;
      rsp_rdata     <= '0;
      rsp_sem_owned <= 1'b0;
    end else begin
      rsp_valid <= (state == ST_STROBE) && (cnt == '0) && !init_pending;
      if (state == ST_STROBE && cnt == '0 && !is_write) begin
        rsp_rdata     <= din_s2;
        rsp_sem_owned <= is_sem && !din_s2[0];
      end
    end
  end

  property p_sem_space;
    @(posedge mclk) disable iff (!nrst)
      !flag_space_select_n |-> ce_n;
  endproperty
  a_sem_space: assert property (p_sem_space)
    else $error("semaphore select with chip enable active");

  property p_init_mbox;
    @(posedge mclk) disable iff (!nrst)
      (init_pending && !oe_n) |-> (addr == (PORT_RIGHT ? MBOX_RIGHT : MBOX_LEFT)) && !ce_n;
  endproperty
  a_init_mbox: assert property (p_init_mbox)
    else $error("initial access is not own mailbox read");

  property p_no_rsp_init;
    @(posedge mclk) disable iff (!nrst)
      $fell(init_pending) |-> !rsp_valid && (state == ST_IDLE);
  endproperty
  a_no_rsp_init: assert property (p_no_rsp_init)
    else $error("init access produced a response");

  property p_hold;
    @(posedge mclk) disable iff (!nrst)
      write_lock |=> !slave_busy_hold_n;
  endproperty
  a_hold: assert property (p_hold)
    else $error("write lock not reflected on busy hold");

  property p_busy_stall;
    @(posedge mclk) disable iff (!nrst)
      (state == ST_WAIT && is_write && !own_busy_ok) |=> (state == ST_WAIT) && rw_n;
  endproperty
  a_busy_stall: assert property (p_busy_stall)
    else $error("write strobed while array busy");

  property p_conflict;
    @(posedge mclk) disable iff (!nrst)
      (!left_conflict_flag_n[0] || !right_conflict_flag_n[0]) ##1 1'b1 ##1 1'b1
        |=> conflict_irq;
  endproperty
  a_conflict: assert property (p_conflict)
    else $error("busy not reported on conflict interrupt");

  property p_wr_pulse;
    @(posedge mclk) disable iff (!nrst)
      $fell(rw_n) |-> (!rw_n && data_oe)[*6] ##1 rw_n;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write pulse length wrong");
endmodule

// ### include/dpmh_pkg.sv
package dpmh_pkg;
  // Pin geometry of the dual-port device
  localparam int ADDR_W     = 16;
  localparam int DATA_W     = 18;
  localparam int DEV_N      = 2;   // Devices stacked in depth
  localparam int SEM_IDX_W  = 3;

  // Mailbox locations
  localparam logic [15:0] MBOX_LEFT  = 16'hfffe;
  localparam logic [15:0] MBOX_RIGHT = 16'hffff;

  // Timing, printed figures in ns and derived cycle counts
  localparam int CLK_NS     = 5;
  localparam int T_ACC_NS   = 20;  // Access and write pulse, least
  localparam int T_BAA_NS   = 20;  // Busy valid after address match, longest
  localparam int SYNC_CYC   = 2;
  localparam int ACC_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int BAA_CYC    = (T_BAA_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = ACC_CYC + SYNC_CYC;
  localparam int SETUP_CYC  = BAA_CYC + SYNC_CYC;
  localparam int CNT_W      = 4;

  // Reset values
  localparam logic RST_INIT_PENDING = 1'b1;

  // Host commands
  localparam logic [1:0] OP_RAM_RD = 2'h0;
  localparam logic [1:0] OP_RAM_WR = 2'h1;
  localparam logic [1:0] OP_SEM_RD = 2'h2;
  localparam logic [1:0] OP_SEM_WR = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_WAIT,
    ST_STROBE,
    ST_RECOVER
  } dpmh_state_e;
endpackage

// ### test/dpmh_dev_model.sv
`timescale 1ns/1ps
// Two-port device model, index 0 left and 1 right, sampled on the bench clock
module dpmh_dev_model (
  input  wire logic             mclk,
  input  wire logic [1:0][15:0] addr,
  input  wire logic [1:0][17:0] din,
  output logic      [1:0][17:0] dout,
  input  wire logic [1:0]       ce_n,
  input  wire logic [1:0]       rw_n,
  input  wire logic [1:0]       oe_n,
  input  wire logic [1:0]       sem_n,
  output logic      [1:0]       irq_n,
  output logic      [1:0]       busy_n
);
  logic [17:0]      mem [65536];
  logic [1:0][7:0]  hold = '0;
  logic [1:0][7:0]  req = '0;
  logic [1:0][15:0] pa = '0;
  logic [1:0]       pe = '0;
  logic [1:0]       en;
  logic [2:0]       ix;
  logic             match;
  initial irq_n = 2'b00; // Unknown at power-up, shown as set
  initial busy_n = 2'b11;
  initial dout = '0;
  // Enables and address match only; read or write plays no part
  always_comb begin
    en = ~ce_n;
    match = &en && addr[0] == addr[1];
  end
  // Behavioural access logic; blocking keeps the token update ordered
  always @(posedge mclk) begin
    pe <= en;
    pa <= addr;
    if (!match) busy_n <= 2'b11;
    else if (&busy_n) busy_n <= (pe[0] && pa[0] == addr[0]) ? 2'b01 : 2'b10;
    for (int s = 0; s < 2; s++) begin
      ix = addr[s][2:0];
      if (en[s] && !rw_n[s] && busy_n[s]) begin
        mem[addr[s]] <= din[s];
        if (addr[s] == (16'hfffe | 16'(1 - s))) irq_n[1 - s] <= 1'b0;
      end
      if (en[s] && !oe_n[s] && busy_n[s] && addr[s] == (16'hfffe | 16'(s))) irq_n[s] <= 1'b1;
      if (!sem_n[s] && ce_n[s] && !rw_n[s]) begin
        if (!din[s][0] && !hold[1 - s][ix]) hold[s][ix] = 1'b1;
        else if (!din[s][0]) req[s][ix] = 1'b1;
        else if (hold[s][ix]) begin
          hold[s][ix] = 1'b0;
          hold[1 - s][ix] = req[1 - s][ix];
          req[1 - s][ix] = 1'b0;
        end
      end
      if (!oe_n[s] && rw_n[s] && !sem_n[s] && ce_n[s]) dout[s] <= {18{~hold[s][ix]}};
      else if (!oe_n[s] && rw_n[s] && en[s]) dout[s] <= mem[addr[s]];
      else dout[s] <= ~dout[s]; // Released bus never keeps a stale value
    end
  end
endmodule

// ### test/dual_port_ram_arbitration_mailbox_tb_top.sv
`timescale 1ns/1ps
module dual_port_ram_arbitration_mailbox_tb_top;
  import dpmh_pkg::*;
  logic mclk = 0, nrst = 0, cmd_valid = 0, write_lock = 0;
  logic [1:0] cmd_op = 0;
  logic [15:0] cmd_addr = 0, l_addr, r_addr = 0;
  logic [17:0] cmd_wdata = 0, rsp_rdata, l_do, r_din = 0, r_seen;
  logic [1:0][17:0] dq;
  logic [1:0] irq_n, busy_n;
  logic cmd_ready, rsp_valid, rsp_sem_owned, init_done, mailbox_irq, conflict_irq;
  logic l_oe, l_ce_n, l_rw_n, l_oe_n, l_sem_n, hold_n;
  logic r_ce_n = 1, r_rw_n = 1, r_oe_n = 1, r_sem_n = 1;
  int num_errors = 0, n_tests = 0;
  initial forever #2.5 mclk = ~mclk;
  dpmh_host #(.PORT_RIGHT(1'b0)) dut (.mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_sem_owned(rsp_sem_owned),
    .init_done(init_done), .write_lock(write_lock), .mailbox_irq(mailbox_irq),
    .conflict_irq(conflict_irq), .addr(l_addr), .data_out(l_do), .data_oe(l_oe),
    .data_in(dq[0]), .ce_n(l_ce_n), .rw_n(l_rw_n), .oe_n(l_oe_n),
    .flag_space_select_n(l_sem_n), .own_mailbox_irq_n(irq_n[0]),
    .left_conflict_flag_n({2{busy_n[0]}}), .right_conflict_flag_n({2{busy_n[1]}}),
    .slave_busy_hold_n(hold_n));
  dpmh_dev_model dev (.mclk(mclk), .addr({r_addr, l_addr}), .din({r_din, l_do}), .dout(dq),
    .ce_n({r_ce_n, l_ce_n}), .rw_n({r_rw_n, l_rw_n}), .oe_n({r_oe_n, l_oe_n}),
    .sem_n({r_sem_n, l_sem_n}), .irq_n(irq_n), .busy_n(busy_n));
  task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Steps land 1 ns after the edge so nothing races the sampling edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wait_hi(ref logic sig);
    for (int n = 0; sig !== 1'b1; n++) begin
      if (n > 400) begin
        chk("handshake", 0, 1);
        results();
      end
      tick(1);
    end
  endtask
  task automatic cmd(input logic [1:0] op, input logic [15:0] a, input logic [17:0] d);
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1;
    wait_hi(cmd_ready);
    tick(1);
    cmd_valid = 0;
    wait_hi(rsp_valid);
  endtask
  // Right port access; ctl is ce_n, rw_n, oe_n, sem_n
  task automatic rport(input logic [3:0] ctl, input logic [15:0] a, input logic [17:0] d);
    {r_ce_n, r_rw_n, r_oe_n, r_sem_n} = ctl;
    r_addr = a;
    r_din = d;
    tick(8);
    r_seen = dq[1];
    {r_ce_n, r_rw_n, r_oe_n, r_sem_n} = 4'hf;
    tick(1);
  endtask
  task automatic t_start();
    wait_hi(init_done);
    chk("own irq pin", irq_n[0], 1);
    rport(4'b0101, MBOX_RIGHT, 0);
    chk("far irq pin", irq_n[1], 1);
    cmd(OP_SEM_RD, 16'h0005, 0);
    chk("sem at start", rsp_rdata, 18'h3ffff);
    $display("start done");
  endtask
  task automatic t_ram_mbox();
    cmd(OP_RAM_WR, 16'h1234, 18'h2a5c3);
    cmd(OP_RAM_RD, 16'h1234, 0);
    chk("ram word", rsp_rdata, 18'h2a5c3);
    cmd(OP_RAM_WR, MBOX_RIGHT, 18'h00011);
    chk("right irq set", irq_n[1], 0);
    rport(4'b0101, MBOX_RIGHT, 0);
    chk("right irq clear", irq_n[1], 1);
    rport(4'b0011, MBOX_LEFT, 18'h00022);
    tick(4);
    chk("mailbox irq", mailbox_irq, 1);
    cmd(OP_RAM_RD, MBOX_LEFT, 0);
    tick(4);
    chk("mailbox cleared", mailbox_irq, 0);
    $display("ram and mailbox done");
  endtask
  task automatic t_sem();
    cmd(OP_SEM_WR, 16'h0005, 18'h0);
    cmd(OP_SEM_RD, 16'h0005, 0);
    chk("sem granted", rsp_rdata, 18'h0);
    chk("sem owned", rsp_sem_owned, 1);
    rport(4'b1010, 16'h0005, 18'h0);
    rport(4'b1100, 16'h0005, 0);
    chk("far side view", r_seen, 18'h3ffff);
    cmd(OP_SEM_WR, 16'h0005, 18'h1);
    rport(4'b1100, 16'h0005, 0);
    chk("token passed", r_seen, 18'h0);
    cmd(OP_SEM_RD, 16'h0005, 0);
    chk("sem lost", rsp_sem_owned, 0);
    rport(4'b1010, 16'h0005, 18'h1);
    cmd(OP_SEM_RD, 16'h0005, 0);
    chk("sem freed", rsp_rdata, 18'h3ffff);
    $display("semaphore done");
  endtask
  task automatic t_busy();
    {r_ce_n, r_oe_n, r_addr} = {2'b00, 16'h0100};
    tick(2);
    fork
      cmd(OP_RAM_WR, 16'h0100, 18'h15a5a);
      begin
        tick(30);
        chk("busy pair", busy_n, 2'b10);
        chk("conflict irq", conflict_irq, 1);
        chk("write held", l_rw_n, 1);
        chk("write pending", cmd_ready, 0);
        {r_ce_n, r_oe_n} = 2'b11;
      end
    join
    cmd(OP_RAM_RD, 16'h0100, 0);
    chk("late write", rsp_rdata, 18'h15a5a);
    write_lock = 1;
    tick(2);
    chk("slave hold", hold_n, 0);
    write_lock = 0;
    $display("busy done");
  endtask
  initial begin
    tick(2);
    nrst = 1;
    t_start();
    t_ram_mbox();
    t_sem();
    t_busy();
    results();
  end
endmodule
